// ==== logic/xcc_capture.sv ====
// fault address and fault status capture with special register read port
module xcc_capture
  import xcc_pkg::*;
(
  input  wire logic              I_CLOCK,
  input  wire logic              I_RESET,
  input  wire logic              I_CLOCK_EN,
  input  wire logic              I_WORD64,
  input  wire logic              I_FAULT_VALID,
  input  wire xcc_fault_t        I_FAULT,
  input  wire logic              I_DIV_FAULT,
  input  wire logic              I_DIV_STICKY_CLR,
  input  wire logic              I_HW_FAULT_EN_WR,
  input  wire logic              I_HW_FAULT_EN_DATA,
  input  wire logic              I_RD_VALID,
  input  wire xcc_rd_kind_t      I_RD_KIND,
  input  wire logic [SEL_W-1:0]  I_RD_SEL,
  output logic                   O_FAULT_TAKEN,
  output logic                   O_HW_FAULT_ENABLE,
  output logic                   O_DIVIDE_FAULT_STICKY,
  output logic                   O_RD_HIT,
  output logic [WORD_W-1:0]      O_RD_DATA
);

  logic [ADDR_W-1:0] fault_address_reg;
  logic [WORD_W-1:0] fault_status_reg;
  logic [WORD_W-1:0] status_next;
  logic              hw_fault_enable_reg;
  logic              divide_fault_sticky_reg;
  logic              taken_next;
  logic              taken_reg;
  logic              rd_hit_reg;
  logic              rd_hit_next;
  logic [WORD_W-1:0] rd_data_reg;
  logic [WORD_W-1:0] rd_data_next;

  xcc_status_pack u_pack (
    .i_fault  (I_FAULT),
    .i_word64 (I_WORD64),
    .o_status (status_next)
  );

  // memory management faults always pass; others need the enable
  assign taken_next = I_FAULT_VALID & (xcc_is_mmu(I_FAULT.cause) | hw_fault_enable_reg);

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      hw_fault_enable_reg <= HW_FAULT_EN_RESET;
    end else if (I_CLOCK_EN && I_HW_FAULT_EN_WR) begin
      hw_fault_enable_reg <= I_HW_FAULT_EN_DATA;
    end
  end

  // address is captured for every taken fault; software only trusts it for the
  // six address-reporting causes, so no per-cause gating is spent here
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      fault_address_reg <= FAULT_ADDRESS_RESET;
    end else if (I_CLOCK_EN && taken_next) begin
      fault_address_reg <= I_FAULT.addr;
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      fault_status_reg <= FAULT_STATUS_RESET;
    end else if (I_CLOCK_EN && taken_next) begin
      fault_status_reg <= status_next;
    end
  end

  // sticky divide flag: set wins over a same-cycle clear
  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      divide_fault_sticky_reg <= 1'b0;
    end else if (I_CLOCK_EN) begin
      if (I_DIV_FAULT || (I_FAULT_VALID && I_FAULT.cause == CAUSE_DIVIDE)) begin
        divide_fault_sticky_reg <= 1'b1;
      end else if (I_DIV_STICKY_CLR) begin
        divide_fault_sticky_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      taken_reg <= 1'b0;
    end else if (I_CLOCK_EN) begin
      taken_reg <= taken_next;
    end
  end

  // read mux; the registers are read as they stand before any same-cycle capture
  always_comb begin
    rd_hit_next  = 1'b0;
    rd_data_next = '0;
    if (I_RD_VALID) begin
      if (I_RD_SEL == SEL_FAULT_ADDRESS) begin
        rd_hit_next = 1'b1;
        if (I_WORD64) begin
          rd_data_next = fault_address_reg;
        end else if (I_RD_KIND == XCC_RD_UPPER) begin
          rd_data_next = {32'h0, fault_address_reg[ADDR_W-1:32]};
        end else begin
          rd_data_next = {32'h0, fault_address_reg[31:0]};
        end
      end else if (I_RD_SEL == SEL_FAULT_STATUS && I_RD_KIND == XCC_RD_LOW) begin
        rd_hit_next  = 1'b1;
        rd_data_next = I_WORD64 ? fault_status_reg : {32'h0, fault_status_reg[31:0]};
      end
    end
  end

  always_ff @(posedge I_CLOCK) begin
    if (I_RESET) begin
      rd_hit_reg  <= 1'b0;
      rd_data_reg <= '0;
    end else if (I_CLOCK_EN) begin
      rd_hit_reg  <= rd_hit_next;
      rd_data_reg <= rd_data_next;
    end
  end

  assign O_FAULT_TAKEN         = taken_reg;
  assign O_HW_FAULT_ENABLE     = hw_fault_enable_reg;
  assign O_DIVIDE_FAULT_STICKY = divide_fault_sticky_reg;
  assign O_RD_HIT              = rd_hit_reg;
  assign O_RD_DATA             = rd_data_reg;

endmodule

// ==== logic/xcc_pkg.sv ====
// constants, types and helpers for the exception cause capture block
// Overview of operation
// - unaligned data access loads fault address with the full misaligned data address
// - peripheral data port fault loads fault address with the failing bus access address
// - storage and TLB miss faults load the virtual effective address into fault address
// - fault address content is meaningless for all other causes
// - selector 0x0003 on either move-from-special read returns the fault address
// - 32-bit core: plain read gives low 32 bits, upper read gives high bits
// - 64-bit core: one plain read returns the whole fault address
// - selector 0x0005 on a plain read returns the fault status register
// - delay-slot flag at bit 19 (51) is 1 for delay-slot faults
// - cause codes: stream 0, unaligned 1, illegal 2, ibus 3, dbus 4
// - cause codes: divide 5, floating point 6, privileged 7, stack protect 7
// - cause codes: data storage 16, instr storage 17, data TLB 18, instr TLB 19
// - unaligned detail: store flag, word flag, long flag only in 64-bit mode
// - unaligned detail bits 22:26 hold the source or destination register index
// - bus error detail bit 20 flags a local memory bus ECC error
// - divide detail bit 20: 0 divide by zero, 1 overflow
// - stream detail bits 23:26 hold link index, bits 20:22 zero
// - data storage detail: bit 20 zone protection, bit 21 store
// - instruction storage detail: bit 20 zone protection, rest zero
// - data TLB miss detail: bit 21 store, bit 20 zero
// - the four memory management causes are never masked by the enable
// - divide sticky flag sets on any divide fault regardless of exception handling
// - hardware fault enable masks maskable faults when 0, resets to 0
package xcc_pkg;

  localparam int ADDR_W   = 64;
  localparam int WORD_W   = 64;
  localparam int SEL_W    = 14;
  localparam int CAUSE_W  = 5;

  localparam logic [SEL_W-1:0] SEL_FAULT_ADDRESS = 14'h0003;
  localparam logic [SEL_W-1:0] SEL_FAULT_STATUS  = 14'h0005;

  // little-endian positions, same in both core widths; big-endian bit n maps to 31-n (63-n in 64-bit numbering)
  localparam int POS_CAUSE_LSB   = 0;
  localparam int POS_DETAIL_LSB  = 5;
  localparam int POS_REG_IDX_LSB = 5;
  localparam int POS_LINK_LSB    = 5;
  localparam int POS_STORE       = 10;
  localparam int POS_DETAIL20    = 11;
  localparam int POS_DELAY_SLOT  = 12;
  localparam int POS_LONG        = 13;

  localparam logic [ADDR_W-1:0] FAULT_ADDRESS_RESET = 64'h0;
  localparam logic [WORD_W-1:0] FAULT_STATUS_RESET  = 64'h0;
  localparam logic              HW_FAULT_EN_RESET   = 1'b0;

  localparam logic [CAUSE_W-1:0] CAUSE_STREAM       = 5'h00;
  localparam logic [CAUSE_W-1:0] CAUSE_UNALIGNED    = 5'h01;
  localparam logic [CAUSE_W-1:0] CAUSE_ILLEGAL_OP   = 5'h02;
  localparam logic [CAUSE_W-1:0] CAUSE_INSTR_BUS    = 5'h03;
  localparam logic [CAUSE_W-1:0] CAUSE_DATA_BUS     = 5'h04;
  localparam logic [CAUSE_W-1:0] CAUSE_DIVIDE       = 5'h05;
  localparam logic [CAUSE_W-1:0] CAUSE_FLOAT        = 5'h06;
  localparam logic [CAUSE_W-1:0] CAUSE_PRIVILEGED   = 5'h07;
  localparam logic [CAUSE_W-1:0] CAUSE_STACK_PROT   = 5'h07;
  localparam logic [CAUSE_W-1:0] CAUSE_DATA_STORAGE = 5'h10;
  localparam logic [CAUSE_W-1:0] CAUSE_INST_STORAGE = 5'h11;
  localparam logic [CAUSE_W-1:0] CAUSE_DATA_TLB     = 5'h12;
  localparam logic [CAUSE_W-1:0] CAUSE_INST_TLB     = 5'h13;

  typedef struct packed {
    logic [CAUSE_W-1:0] cause;
    logic [ADDR_W-1:0]  addr;
    logic               delay_slot;
    logic               is_store;
    logic               is_word;
    logic               is_long;
    logic [4:0]         reg_idx;
    logic               ecc_err;
    logic               div_overflow;
    logic [3:0]         stream_link_index;
    logic               zone_protect_hit;
  } xcc_fault_t;

  typedef enum logic {
    XCC_RD_LOW,
    XCC_RD_UPPER
  } xcc_rd_kind_t;

  // memory management causes bypass the enable
  function automatic logic xcc_is_mmu(input logic [CAUSE_W-1:0] c);
    return (c == CAUSE_DATA_STORAGE) || (c == CAUSE_INST_STORAGE) ||
           (c == CAUSE_DATA_TLB) || (c == CAUSE_INST_TLB);
  endfunction

endpackage

// ==== logic/xcc_status_pack.sv ====
// builds the fault status word from one fault record
module xcc_status_pack
  import xcc_pkg::*;
(
  input  wire xcc_fault_t        i_fault,
  input  wire logic              i_word64,
  output logic [WORD_W-1:0]      o_status
);

  always_comb begin
    o_status = '0;
    o_status[POS_CAUSE_LSB +: CAUSE_W] = i_fault.cause;
    o_status[POS_DELAY_SLOT] = i_fault.delay_slot;
    // every detail bit starts at zero; only the cause's own fields are filled
    case (i_fault.cause)
      CAUSE_UNALIGNED: begin
        o_status[POS_DETAIL20] = i_fault.is_word;
        o_status[POS_STORE]    = i_fault.is_store;
        o_status[POS_LONG]     = i_word64 & i_fault.is_long;
        o_status[POS_REG_IDX_LSB +: 5] = i_fault.reg_idx;
      end
      CAUSE_INSTR_BUS, CAUSE_DATA_BUS: begin
        o_status[POS_DETAIL20] = i_fault.ecc_err;
      end
      CAUSE_DIVIDE: begin
        o_status[POS_DETAIL20] = i_fault.div_overflow;
      end
      CAUSE_STREAM: begin
        o_status[POS_LINK_LSB +: 4] = i_fault.stream_link_index;
      end
      CAUSE_DATA_STORAGE: begin
        o_status[POS_DETAIL20] = i_fault.zone_protect_hit;
        o_status[POS_STORE]    = i_fault.is_store;
      end
      CAUSE_INST_STORAGE: begin
        o_status[POS_DETAIL20] = i_fault.zone_protect_hit;
      end
      CAUSE_DATA_TLB: begin
        o_status[POS_STORE] = i_fault.is_store;
      end
      default: begin
      end
    endcase
  end

endmodule

// ==== sim/xcc_capture_asserts.sv ====
// port-level assertions for the fault capture block
module xcc_capture_asserts
  import xcc_pkg::*;
(
  input wire logic             I_CLOCK,
  input wire logic             I_RESET,
  input wire logic             I_CLOCK_EN,
  input wire logic             I_WORD64,
  input wire logic             I_FAULT_VALID,
  input wire xcc_fault_t       I_FAULT,
  input wire logic             I_DIV_FAULT,
  input wire logic             I_HW_FAULT_EN_WR,
  input wire logic             I_HW_FAULT_EN_DATA,
  input wire logic             I_RD_VALID,
  input wire xcc_rd_kind_t     I_RD_KIND,
  input wire logic [SEL_W-1:0] I_RD_SEL,
  input wire logic             O_FAULT_TAKEN,
  input wire logic             O_HW_FAULT_ENABLE,
  input wire logic             O_DIVIDE_FAULT_STICKY,
  input wire logic             O_RD_HIT,
  input wire logic [WORD_W-1:0] O_RD_DATA
);
  default clocking @(posedge I_CLOCK); endclocking
  default disable iff (I_RESET);
  chk_mmu_taken: assert property (I_CLOCK_EN && I_FAULT_VALID && I_FAULT.cause[4] |=> O_FAULT_TAKEN)
    else $error("memory fault not taken");
  chk_mask_gate: assert property (I_CLOCK_EN && I_FAULT_VALID && !I_FAULT.cause[4] |=> O_FAULT_TAKEN == $past(O_HW_FAULT_ENABLE))
    else $error("maskable fault gating wrong");
  chk_taken_cause: assert property (O_FAULT_TAKEN |-> $past(I_FAULT_VALID) || !$past(I_CLOCK_EN))
    else $error("fault taken without request");
  chk_addr_hit: assert property (I_CLOCK_EN && I_RD_VALID && I_RD_SEL == SEL_FAULT_ADDRESS |=> O_RD_HIT)
    else $error("address read missed");
  chk_status_hit: assert property (I_CLOCK_EN && I_RD_VALID && I_RD_SEL == SEL_FAULT_STATUS |=> O_RD_HIT == ($past(I_RD_KIND) == XCC_RD_LOW))
    else $error("status read hit wrong");
  chk_miss_zero: assert property (!O_RD_HIT |-> O_RD_DATA == '0)
    else $error("data without hit");
  chk_narrow_upper: assert property (!I_WORD64 && O_RD_HIT |-> O_RD_DATA[63:32] == 32'h0)
    else $error("upper half not zero");
  chk_div_sticky: assert property (I_CLOCK_EN && (I_DIV_FAULT || I_FAULT_VALID && I_FAULT.cause == CAUSE_DIVIDE) |=> O_DIVIDE_FAULT_STICKY)
    else $error("divide sticky not set");
  chk_en_write: assert property (I_CLOCK_EN && I_HW_FAULT_EN_WR |=> O_HW_FAULT_ENABLE == $past(I_HW_FAULT_EN_DATA))
    else $error("enable write lost");
  cov_taken: cover property (O_FAULT_TAKEN);
  cov_upper: cover property (I_RD_VALID && I_RD_KIND == XCC_RD_UPPER && !I_WORD64);
  cov_refused: cover property (I_FAULT_VALID && !I_FAULT.cause[4] && !O_HW_FAULT_ENABLE);
endmodule
bind xcc_capture xcc_capture_asserts xcc_capture_asserts_i (.*);

// ==== sim/xcc_capture_bench.sv ====
// self-checking bench for the fault capture block
module xcc_capture_bench;
  import xcc_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic I_CLOCK = 0, I_RESET = 1, w64 = 1, fv = 0, dvf = 0, clr = 0, ew = 0, ed = 0, rv = 0;
  xcc_fault_t fr = '0;
  xcc_rd_kind_t rk = XCC_RD_LOW;
  logic [13:0] rs = '0;
  logic tk, hit, stk, en;
  logic [63:0] rdat, addr_m, stat_m;
  int errors = 0, n_compared = 0, seed = 79340;
  logic [4:0] causes [12] = '{5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h10, 5'h11, 5'h12, 5'h13};
  always #4 I_CLOCK = ~I_CLOCK;
  xcc_capture xcc_capture_i (.I_CLOCK(I_CLOCK), .I_RESET(I_RESET), .I_CLOCK_EN(1'b1), .I_WORD64(w64),
    .I_FAULT_VALID(fv), .I_FAULT(fr), .I_DIV_FAULT(dvf), .I_DIV_STICKY_CLR(clr), .I_HW_FAULT_EN_WR(ew),
    .I_HW_FAULT_EN_DATA(ed), .I_RD_VALID(rv), .I_RD_KIND(rk), .I_RD_SEL(rs), .O_FAULT_TAKEN(tk),
    .O_HW_FAULT_ENABLE(en), .O_DIVIDE_FAULT_STICKY(stk), .O_RD_HIT(hit), .O_RD_DATA(rdat));
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  function automatic logic [63:0] model_stat(input xcc_fault_t f);
    logic [63:0] s;
    s = '0;
    s[4:0] = f.cause;
    s[12] = f.delay_slot;
    case (f.cause)
      5'h01: s[13:5] = {w64 & f.is_long, f.delay_slot, f.is_word, f.is_store, f.reg_idx};
      5'h03, 5'h04: s[11] = f.ecc_err;
      5'h05: s[11] = f.div_overflow;
      5'h00: s[8:5] = f.stream_link_index;
      5'h10: s[11:10] = {f.zone_protect_hit, f.is_store};
      5'h11: s[11] = f.zone_protect_hit;
      5'h12: s[10] = f.is_store;
      default: ;
    endcase
    return s;
  endfunction
  task automatic fault(input logic [4:0] c, input logic en_m, inout logic stk_m);
    logic [95:0] r;
    xcc_fault_t f;
    r = {$random(seed), $random(seed), $random(seed)};
    f = r[84:0];
    f.cause = c;
    @(posedge I_CLOCK) fv <= 1;
    fr <= f;
    @(posedge I_CLOCK) fv <= 0;
    #1;
    if (c[4] | en_m) begin
      addr_m = f.addr;
      stat_m = model_stat(f);
    end
    stk_m = stk_m | (c == 5'h05);
    cmp(tk, c[4] | en_m);
    cmp(stk, stk_m);
  endtask
  task automatic rd(input xcc_rd_kind_t k, input logic [13:0] s);
    logic [63:0] e;
    e = '0;
    if (s == SEL_FAULT_ADDRESS) e = w64 ? addr_m : (k == XCC_RD_LOW ? addr_m[31:0] : addr_m[63:32]);
    if (s == SEL_FAULT_STATUS && k == XCC_RD_LOW) e = w64 ? stat_m : stat_m[31:0];
    @(posedge I_CLOCK) rv <= 1;
    rk <= k;
    rs <= s;
    @(posedge I_CLOCK) rv <= 0;
    #1 cmp(hit, s == SEL_FAULT_ADDRESS || (s == SEL_FAULT_STATUS && k == XCC_RD_LOW));
    cmp(rdat, e);
  endtask
  task automatic ctl(input logic wr, input logic v, input logic dv, input logic cl, inout logic stk_m);
    @(posedge I_CLOCK) ew <= wr;
    ed <= v;
    dvf <= dv;
    clr <= cl;
    @(posedge I_CLOCK) ew <= 0;
    dvf <= 0;
    clr <= 0;
    #1 stk_m = dv | (stk_m & ~cl);
    cmp(stk, stk_m);
    if (wr) cmp(en, v);
  endtask
  initial begin
    logic sm;
    for (int ph = 0; ph < 2; ph++) begin
      @(posedge I_CLOCK) I_RESET <= 1;
      w64 <= (ph == 0);
      repeat (8) @(posedge I_CLOCK);
      I_RESET <= 0;
      #1 addr_m = '0;
      stat_m = '0;
      sm = 0;
      cmp(en, 1'b0);
      rd(XCC_RD_LOW, SEL_FAULT_STATUS);
      rd(XCC_RD_UPPER, SEL_FAULT_ADDRESS);
      for (int e = 0; e < 2; e++) begin
        ctl(1'b1, e[0], 1'b0, 1'b1, sm);
        foreach (causes[i]) begin
          fault(causes[i], e[0], sm);
          rd(XCC_RD_LOW, SEL_FAULT_ADDRESS);
          rd(XCC_RD_UPPER, SEL_FAULT_ADDRESS);
          rd(XCC_RD_LOW, SEL_FAULT_STATUS);
          rd(XCC_RD_UPPER, SEL_FAULT_STATUS);
          rd(XCC_RD_LOW, 14'($random(seed)));
        end
      end
      ctl(1'b0, 1'b0, 1'b1, 1'b1, sm);
      ctl(1'b0, 1'b0, 1'b0, 1'b1, sm);
      ctl(1'b0, 1'b0, 1'b1, 1'b0, sm);
    end
    close_out();
  end
endmodule
